// File: rtcaw_pkg.sv
// package of constants and types for the alarm and window block
package rtcaw_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_ALARM_CFG = 8'h00;
  localparam logic [7:0] OFS_VAL_HIGH = 8'h04;
  localparam logic [7:0] OFS_VAL_LOW = 8'h08;
  localparam logic [7:0] OFS_WINDOW = 8'h0c;
  localparam logic [7:0] OFS_CONTROL = 8'h10;
  localparam logic [7:0] OFS_TIME_SEL = 8'h14;
  localparam logic [7:0] OFS_TIME_RD = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  // alarm config field positions
  localparam int EN_BIT = 15;
  localparam int CHIME_BIT = 14;
  localparam int MASK_LSB = 10;
  localparam int PTR_LSB = 8;
  // control register bits
  localparam int CTL_UNLOCK = 0;
  localparam int CTL_PWC_EN = 1;
  // interrupt status bits
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_STAB_END = 1;
  localparam int IRQ_SAMP_END = 2;
  localparam int IRQ_W = 3;
  // reset values
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] WIN_RESET = 16'h0000;
  // power-control clock divider, period in ns
  localparam int PWC_PERIOD_NS = 1000;
  localparam int CLK_NS = 5;
  localparam int PWC_DIV = PWC_PERIOD_NS / CLK_NS;
  localparam logic [7:0] SAMP_ALWAYS = 8'hff;
  // alarm interval codes
  typedef enum logic [3:0] {
    RTCAW_HALF_SEC = 4'h0, RTCAW_SEC = 4'h1, RTCAW_TEN_SEC = 4'h2,
    RTCAW_MIN = 4'h3, RTCAW_TEN_MIN = 4'h4, RTCAW_HOUR = 4'h5,
    RTCAW_DAY = 4'h6, RTCAW_WEEK = 4'h7, RTCAW_MONTH = 4'h8,
    RTCAW_YEAR = 4'h9
  } rtcaw_interval_e;
  // calendar time, bcd-free binary fields
  typedef struct packed {
    logic half;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] day;
    logic [7:0] month;
  } rtcaw_time_s;
  // window timer states
  typedef enum logic [1:0] {
    RTCAW_IDLE = 2'b00, RTCAW_STAB = 2'b01, RTCAW_SAMP = 2'b11
  } rtcaw_state_e;
endpackage

// File: rtcaw_pwc_div.sv
// divider making the power-control clock enable pulse
`timescale 1ns/10ps
`default_nettype none
module rtcaw_pwc_div (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  localparam int W = $clog2(rtcaw_pkg::PWC_DIV);
  logic [W-1:0] cnt;
  // count one power-control period then pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt == W'(rtcaw_pkg::PWC_DIV - 1)) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: rtcaw_match.sv
// compare of current time against alarm value per interval
`timescale 1ns/10ps
`default_nettype none
module rtcaw_match (
  input wire rtcaw_pkg::rtcaw_time_s now,
  input wire rtcaw_pkg::rtcaw_time_s alarm,
  input wire logic [3:0] interval,
  output logic hit
);
  logic s, m, h, d, w, mo;
  // field compares, tens-of compares use the units digit only
  always_comb begin
    s = (now.sec == alarm.sec);
    m = (now.min == alarm.min);
    h = (now.hour == alarm.hour);
    d = (now.day == alarm.day);
    w = (now.wday == alarm.wday);
    mo = (now.month == alarm.month);
    case (interval)
      4'h0: hit = 1'b1;
      4'h1: hit = !now.half;
      4'h2: hit = !now.half && (now.sec % 8'd10 == alarm.sec % 8'd10);
      4'h3: hit = !now.half && s;
      4'h4: hit = !now.half && s && (now.min % 8'd10 == alarm.min % 8'd10);
      4'h5: hit = !now.half && s && m;
      4'h6: hit = !now.half && s && m && h;
      4'h7: hit = !now.half && s && m && h && w;
      4'h8: hit = !now.half && s && m && h && d;
      4'h9: hit = !now.half && s && m && h && d && mo;
      default: hit = 1'b0; // reserved codes never fire
    endcase
  end
endmodule
`default_nettype wire

// File: rtcaw_top.sv
// alarm repeat control and power-control window timers with apb slave
// How it works
// RULE1 - enable bit self-clears when count zero, no chime
// RULE2 - repeat count decrements on each alarm event
// RULE3 - count wraps zero to ff only with chime
// RULE4 - count value gives number of further alarms
// RULE5 - interval code selects which fields must match
// RULE6 - pointer picks fields shown in value windows
// RULE7 - high window access decrements pointer, floor zero
// RULE8 - stability length in power-control clock periods
// RULE9 - stability timer starts at alarm when enabled
// RULE10 - sample length n gives n periods
// RULE11 - sample length ff keeps window always open
// RULE12 - sample timer starts when stability ends
// RULE13 - zero stability starts sample at alarm
// RULE14 - window register writes need unlock bit
// RULE15 - alarm fires on time match while enabled
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module rtcaw_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rtcaw_pkg::rtcaw_time_s now,
  input wire logic time_step,
  output logic alarm_pulse,
  output logic stab_window,
  output logic samp_window,
  output logic irq
);
  // -------------------------------------------------------------
  // register state
  // -------------------------------------------------------------
  logic alarm_enable_bit;
  logic chime;
  logic [3:0] alarm_interval_select;
  logic [1:0] alarm_value_pointer;
  logic [7:0] alarm_repeat_count;
  rtcaw_pkg::rtcaw_time_s alarm_val;
  logic [7:0] stability_window_length;
  logic [7:0] sample_window_length;
  logic clock_write_unlock;
  logic power_control_enable;
  logic [rtcaw_pkg::IRQ_W-1:0] irq_stat;
  logic [rtcaw_pkg::IRQ_W-1:0] irq_mask;
  logic [2:0] time_sel;
  logic hit;
  logic pwc_tick;
  logic alarm_event;
  logic stab_done;
  logic samp_done;
  rtcaw_pkg::rtcaw_state_e state;
  logic [7:0] win_cnt;

  // -------------------------------------------------------------
  // apb decode
  // -------------------------------------------------------------
  logic wr, rd, known;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  // unmapped offsets answer with an error
  always_comb begin
    case (paddr)
      rtcaw_pkg::OFS_ALARM_CFG, rtcaw_pkg::OFS_VAL_HIGH,
      rtcaw_pkg::OFS_VAL_LOW, rtcaw_pkg::OFS_WINDOW,
      rtcaw_pkg::OFS_CONTROL, rtcaw_pkg::OFS_TIME_SEL,
      rtcaw_pkg::OFS_TIME_RD, rtcaw_pkg::OFS_IRQ_STAT,
      rtcaw_pkg::OFS_IRQ_MASK: known = 1'b1;
      default: known = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !known;
  logic hi_acc, lo_acc;
  assign hi_acc = psel && penable && (paddr == rtcaw_pkg::OFS_VAL_HIGH);
  assign lo_acc = psel && penable && (paddr == rtcaw_pkg::OFS_VAL_LOW);

  // -------------------------------------------------------------
  // sub blocks
  // -------------------------------------------------------------
  rtcaw_pwc_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick(pwc_tick)
  );
  rtcaw_match u_match (
    .now(now),
    .alarm(alarm_val),
    .interval(alarm_interval_select),
    .hit(hit)
  );

  // alarm event on a time step that matches while enabled
  assign alarm_event = alarm_enable_bit && time_step && hit; // RULE15 RULE5

  // -------------------------------------------------------------
  // alarm config and repeat count
  // -------------------------------------------------------------
  // software write first, alarm event side effects take priority
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_enable_bit <= 1'b0;
      chime <= 1'b0;
      alarm_interval_select <= 4'h0;
      alarm_repeat_count <= 8'h00;
    end else begin
      if (wr && paddr == rtcaw_pkg::OFS_ALARM_CFG) begin
        alarm_enable_bit <= pwdata[rtcaw_pkg::EN_BIT];
        chime <= pwdata[rtcaw_pkg::CHIME_BIT];
        alarm_interval_select <= pwdata[rtcaw_pkg::MASK_LSB +: 4];
        alarm_repeat_count <= pwdata[7:0];
      end
      if (alarm_event) begin
        if (alarm_repeat_count != 8'h00 || chime) begin
          alarm_repeat_count <= alarm_repeat_count - 8'h01; // RULE2 RULE3
        end
        if (alarm_repeat_count == 8'h00 && !chime) begin
          alarm_enable_bit <= 1'b0; // RULE1 RULE4
        end
      end
    end
  end

  // -------------------------------------------------------------
  // pointer and alarm value windows
  // -------------------------------------------------------------
  // cfg write loads pointer; high window access steps it down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_value_pointer <= 2'b00;
    end else if (wr && paddr == rtcaw_pkg::OFS_ALARM_CFG) begin
      alarm_value_pointer <= pwdata[rtcaw_pkg::PTR_LSB +: 2];
    end else if (hi_acc && alarm_value_pointer != 2'b00) begin
      alarm_value_pointer <= alarm_value_pointer - 2'b01; // RULE7
    end
  end

  // window writes land in the field the pointer selects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_val <= '0;
    end else if (wr && hi_acc) begin
      case (alarm_value_pointer)
        2'b00: alarm_val.min <= pwdata[15:8]; // RULE6
        2'b01: alarm_val.wday <= pwdata[15:8];
        2'b10: alarm_val.month <= pwdata[15:8];
        default: ;
      endcase
      case (alarm_value_pointer)
        2'b00: alarm_val.sec <= pwdata[7:0]; // RULE6
        2'b01: alarm_val.hour <= pwdata[7:0];
        2'b10: alarm_val.day <= pwdata[7:0];
        default: ;
      endcase
    end else if (wr && lo_acc) begin
      case (alarm_value_pointer)
        2'b00: alarm_val.sec <= pwdata[7:0];
        2'b01: alarm_val.hour <= pwdata[7:0];
        2'b10: alarm_val.day <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  logic [7:0] win_hi, win_lo;
  // selected field view, unimplemented pointer reads zero
  always_comb begin
    case (alarm_value_pointer)
      2'b00: win_hi = alarm_val.min;
      2'b01: win_hi = alarm_val.wday;
      2'b10: win_hi = alarm_val.month;
      default: win_hi = 8'h00;
    endcase
    case (alarm_value_pointer)
      2'b00: win_lo = alarm_val.sec;
      2'b01: win_lo = alarm_val.hour;
      2'b10: win_lo = alarm_val.day;
      default: win_lo = 8'h00;
    endcase
  end

  // -------------------------------------------------------------
  // control, window timer register, interrupts
  // -------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_write_unlock <= 1'b0;
      power_control_enable <= 1'b0;
      time_sel <= 3'h0;
    end else if (wr && paddr == rtcaw_pkg::OFS_CONTROL) begin
      clock_write_unlock <= pwdata[rtcaw_pkg::CTL_UNLOCK];
      power_control_enable <= pwdata[rtcaw_pkg::CTL_PWC_EN];
    end else if (wr && paddr == rtcaw_pkg::OFS_TIME_SEL) begin
      time_sel <= pwdata[2:0];
    end
  end

  // locked writes are dropped silently
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stability_window_length <= rtcaw_pkg::WIN_RESET[15:8];
      sample_window_length <= rtcaw_pkg::WIN_RESET[7:0];
    end else if (wr && paddr == rtcaw_pkg::OFS_WINDOW
                 && clock_write_unlock) begin // RULE14
      stability_window_length <= pwdata[15:8]; // RULE8
      sample_window_length <= pwdata[7:0];
    end
  end

  logic [rtcaw_pkg::IRQ_W-1:0] events;
  assign events = {samp_done, stab_done, alarm_event};
  // sticky status, set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      if (wr && paddr == rtcaw_pkg::OFS_IRQ_MASK) begin
        irq_mask <= pwdata[rtcaw_pkg::IRQ_W-1:0];
      end
      if (wr && paddr == rtcaw_pkg::OFS_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~pwdata[rtcaw_pkg::IRQ_W-1:0]) | events;
      end else begin
        irq_stat <= irq_stat | events;
      end
    end
  end
  assign irq = |(irq_stat & irq_mask);
  assign alarm_pulse = alarm_event;

  // -------------------------------------------------------------
  // stability and sample window timers
  // -------------------------------------------------------------
  // an alarm event restarts the sequence from stability, or from sample when stability length is zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= rtcaw_pkg::RTCAW_IDLE;
      win_cnt <= 8'h00;
    end else if (!power_control_enable) begin
      state <= rtcaw_pkg::RTCAW_IDLE;
      win_cnt <= 8'h00;
    end else if (alarm_event) begin
      if (stability_window_length != 8'h00) begin
        state <= rtcaw_pkg::RTCAW_STAB; // RULE9
        win_cnt <= stability_window_length;
      end else begin
        state <= rtcaw_pkg::RTCAW_SAMP; // RULE13
        win_cnt <= sample_window_length;
      end
    end else begin
      case (state)
        rtcaw_pkg::RTCAW_STAB: begin
          if (pwc_tick) begin
            if (win_cnt == 8'h01) begin
              state <= rtcaw_pkg::RTCAW_SAMP; // RULE12
              win_cnt <= sample_window_length;
            end else begin
              win_cnt <= win_cnt - 8'h01; // RULE8
            end
          end
        end
        rtcaw_pkg::RTCAW_SAMP: begin
          if (sample_window_length == rtcaw_pkg::SAMP_ALWAYS) begin
            win_cnt <= win_cnt; // RULE11
          end else if (win_cnt == 8'h00) begin
            state <= rtcaw_pkg::RTCAW_IDLE; // RULE10
          end else if (pwc_tick) begin
            win_cnt <= win_cnt - 8'h01;
          end
        end
        rtcaw_pkg::RTCAW_IDLE: win_cnt <= 8'h00;
        default: state <= rtcaw_pkg::RTCAW_IDLE;
      endcase
    end
  end
  assign stab_done = (state == rtcaw_pkg::RTCAW_STAB) && pwc_tick
                     && (win_cnt == 8'h01) && !alarm_event;
  assign samp_done = (state == rtcaw_pkg::RTCAW_SAMP) && (win_cnt == 8'h00)
                     && (sample_window_length != rtcaw_pkg::SAMP_ALWAYS)
                     && !alarm_event;
  assign stab_window = (state == rtcaw_pkg::RTCAW_STAB);
  // all-ones length holds the sample window open always
  assign samp_window = (sample_window_length == rtcaw_pkg::SAMP_ALWAYS)
                       || (state == rtcaw_pkg::RTCAW_SAMP
                           && win_cnt != 8'h00); // RULE11 RULE10

  // -------------------------------------------------------------
  // read data
  // -------------------------------------------------------------
  logic [31:0] next_prdata;
  logic [7:0] tfield;
  always_comb begin
    case (time_sel)
      3'h0: tfield = now.sec;
      3'h1: tfield = now.min;
      3'h2: tfield = now.hour;
      3'h3: tfield = now.wday;
      3'h4: tfield = now.day;
      3'h5: tfield = now.month;
      default: tfield = {7'h00, now.half};
    endcase
    next_prdata = 32'h0000_0000;
    case (paddr)
      rtcaw_pkg::OFS_ALARM_CFG: next_prdata = {16'h0000, alarm_enable_bit,
        chime, alarm_interval_select, alarm_value_pointer,
        alarm_repeat_count};
      rtcaw_pkg::OFS_VAL_HIGH: next_prdata = {16'h0000, win_hi, win_lo};
      rtcaw_pkg::OFS_VAL_LOW: next_prdata = {24'h00_0000, win_lo};
      rtcaw_pkg::OFS_WINDOW: next_prdata = {16'h0000,
        stability_window_length, sample_window_length};
      rtcaw_pkg::OFS_CONTROL: next_prdata = {20'h0_0000,
        samp_window, stab_window, win_cnt, power_control_enable,
        clock_write_unlock};
      rtcaw_pkg::OFS_TIME_SEL: next_prdata = {29'h0000_0000, time_sel};
      rtcaw_pkg::OFS_TIME_RD: next_prdata = {24'h00_0000, tfield};
      rtcaw_pkg::OFS_IRQ_STAT: next_prdata = {29'h0000_0000, irq_stat};
      rtcaw_pkg::OFS_IRQ_MASK: next_prdata = {29'h0000_0000, irq_mask};
      default: next_prdata = 32'h0000_0000;
    endcase
  end
  // read data registered in the setup cycle, valid in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      prdata <= next_prdata;
    end
  end
endmodule
`default_nettype wire

// File: rtcaw_chk.sv
// port checker of the alarm and window block
`timescale 1ns/10ps
`default_nettype none
module rtcaw_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic time_step,
  input wire logic alarm_pulse,
  input wire logic stab_window,
  input wire logic samp_window
);
  int run;
  logic wr_d;
  // ----------------------------------------
  // helper state: window length, last write
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 0;
      wr_d <= 1'b0;
    end else begin
      run <= stab_window ? run + 1 : 0;
      wr_d <= psel && penable && pwrite;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_bad;
    s_acc ##0 paddr > rtcaw_pkg::OFS_IRQ_MASK;
  endsequence
  property p_ready; s_acc |-> pready; endproperty
  property p_err; s_bad |-> pslverr; endproperty
  property p_rd0; s_bad ##0 !pwrite |-> prdata == 32'h0000_0000; endproperty
  property p_ok;
    s_acc ##0 (paddr[1:0] == 2'b00 && paddr <= rtcaw_pkg::OFS_IRQ_MASK)
      |-> !pslverr;
  endproperty
  property p_hi0;
    s_acc ##0 (!pwrite && paddr <= rtcaw_pkg::OFS_WINDOW)
      |-> prdata[31:16] == 16'h0000;
  endproperty
  property p_fire; alarm_pulse |-> time_step; endproperty
  property p_stab; $rose(stab_window) |-> $past(alarm_pulse); endproperty
  property p_samp;
    $rose(samp_window) |-> $past(alarm_pulse) || $fell(stab_window) || wr_d;
  endproperty
  property p_len; run <= 255 * rtcaw_pkg::PWC_DIV; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_err: assert property (p_err) else $error("no error on unmapped");
  a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
  a_ok: assert property (p_ok) else $error("error on mapped place");
  a_hi0: assert property (p_hi0) else $error("upper half not zero");
  a_fire: assert property (p_fire) else $error("alarm without step");
  a_stab: assert property (p_stab) else $error("stab start no alarm");
  a_samp: assert property (p_samp) else $error("samp bad start");
  a_len: assert property (p_len) else $error("stab window too long");
endmodule
bind rtcaw_top rtcaw_chk i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .time_step(time_step), .alarm_pulse(alarm_pulse),
  .stab_window(stab_window), .samp_window(samp_window)
);
`default_nettype wire

// File: rtcaw_tb_top.sv
// self-checking bench of the alarm and window block
`timescale 1ns/10ps
`default_nettype none
module rtcaw_tb_top;
  localparam int D = rtcaw_pkg::PWC_DIV;
  localparam logic [7:0] CFG = rtcaw_pkg::OFS_ALARM_CFG;
  localparam logic [7:0] HI = rtcaw_pkg::OFS_VAL_HIGH;
  localparam logic [7:0] WIN = rtcaw_pkg::OFS_WINDOW;
  localparam logic [7:0] CTL = rtcaw_pkg::OFS_CONTROL;
  logic pclk, presetn, psel, penable, pwrite, time_step, er, h;
  logic pready, pslverr, alarm_pulse, stab_window, samp_window, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  rtcaw_pkg::rtcaw_time_s now;
  int fails, samples_checked, cycles, n, k;
  rtcaw_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .now(now), .time_step(time_step),
    .alarm_pulse(alarm_pulse), .stab_window(stab_window),
    .samp_window(samp_window), .irq(irq)
  );
  // clock and run time ceiling
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    cycles = 0;
    forever begin
      @(posedge pclk);
      cycles++;
      if (cycles == 30000) begin
        fails++;
        complete_run();
      end
    end
  end
  task automatic check(input string s, input logic [31:0] v,
                       input logic [31:0] e);
    samples_checked++;
    if (v !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d, bad %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // apb transfer, read data in rd and error in er
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d = '0);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // one time step, h tells whether the alarm fired
  task automatic step();
    time_step <= 1'b1;
    #2;
    h = alarm_pulse;
    @(posedge pclk);
    time_step <= 1'b0;
    @(posedge pclk);
  endtask
  // clocks that a window stays open, in n
  task automatic span(input logic s);
    n = 0;
    k = 0;
    while ((s ? samp_window : stab_window) !== 1'b1 && k < 5) begin
      @(posedge pclk);
      k++;
    end
    while ((s ? samp_window : stab_window) === 1'b1 && n < 60000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic near(input int l);
    check("window span", n >= (l - 1) * D - 10 && n <= l * D + 2, 1);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    now = '0;
    time_step = 1'b0;
    fails = 0;
    samples_checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    bus(1'b0, CFG);
    check("cfg reset", rd, {16'h0000, rtcaw_pkg::CFG_RESET});
    bus(1'b0, WIN);
    check("window reset", rd, {16'h0000, rtcaw_pkg::WIN_RESET});
    bus(1'b0, 8'h24);
    check("unmapped error", er, 1);
    $display("test reset done");
    // every interval code against a matching time
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, CFG, 32'h0000_8000 | 32'(c << 10));
      step();
      check("interval fire", h, c <= 9);
      bus(1'b0, CFG);
      check("enable left", rd[15], c > 9);
    end
    now.sec <= 8'h01;
    bus(1'b1, CFG, 32'h0000_8C00);
    step();
    check("no match", h, 0);
    now.sec <= 8'h00;
    bus(1'b1, CFG, 32'h0000_8002);
    k = 0;
    repeat (4) begin
      step();
      k += h;
    end
    check("fire count", k, 3);
    bus(1'b0, CFG);
    check("count stop", rd, 0);
    bus(1'b1, CFG, 32'h0000_C000);
    step();
    bus(1'b0, CFG);
    check("chime wrap", rd, 32'h0000_C0FF);
    $display("test repeat done");
    // pointer walk through the value windows
    bus(1'b1, CFG, 32'h0000_0200);
    bus(1'b1, HI, 32'h0000_0A0B);
    bus(1'b0, CFG);
    check("ptr step", rd[9:8], 1);
    bus(1'b1, HI, 32'h0000_0C0D);
    bus(1'b1, HI, 32'h0000_0E0F);
    bus(1'b0, CFG);
    check("ptr floor", rd[9:8], 0);
    bus(1'b1, CFG, 32'h0000_0200);
    bus(1'b0, HI);
    check("month day", rd, 32'h0000_0A0B);
    bus(1'b0, rtcaw_pkg::OFS_VAL_LOW);
    check("hours", rd, 32'h0000_000D);
    bus(1'b0, HI);
    check("wday hours", rd, 32'h0000_0C0D);
    bus(1'b0, HI);
    check("min sec", rd, 32'h0000_0E0F);
    $display("test pointer done");
    // window timers after alarm events
    bus(1'b1, WIN, 32'h0000_0A02);
    bus(1'b0, WIN);
    check("locked", rd, 0);
    bus(1'b1, CTL, 32'h0000_0001);
    bus(1'b1, WIN, 32'h0000_0A02);
    bus(1'b0, WIN);
    check("unlocked", rd, 32'h0000_0A02);
    bus(1'b1, CTL, 32'h0000_0003);
    bus(1'b1, CFG, 32'h0000_8000);
    step();
    span(1'b0);
    near(10);
    span(1'b1);
    near(2);
    bus(1'b1, WIN, 32'h0000_0003);
    bus(1'b1, CFG, 32'h0000_8000);
    step();
    span(1'b0);
    check("no stab", n, 0);
    span(1'b1);
    near(3);
    check("irq masked", irq, 0);
    bus(1'b0, rtcaw_pkg::OFS_IRQ_STAT);
    check("status", rd, 32'h0000_0007);
    bus(1'b1, rtcaw_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    check("irq on", irq, 1);
    bus(1'b1, rtcaw_pkg::OFS_IRQ_STAT, 32'h0000_0001);
    check("irq clear", irq, 0);
    bus(1'b1, CTL, 32'h0000_0001);
    bus(1'b1, WIN, 32'h0000_00FF);
    check("samp open", samp_window, 1);
    $display("test windows done");
    complete_run();
  end
endmodule
`default_nettype wire
